// [inc/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

  // Register map, one byte each on the plain port
  localparam logic [2:0] ADDR_CHANNEL_SELECT = 3'h0;
  localparam logic [2:0] ADDR_RESULT_LOW = 3'h1;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_CLOCK_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;

  // Field positions
  localparam int GO_BIT = 7;
  localparam int CHAN_MSB = 4;
  localparam int CLK_SEL_MSB = 1;

  // Values after reset
  localparam logic [7:0] CHANNEL_SELECT_RESET = 8'h1f;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [1:0] CLOCK_CONTROL_RESET = 2'h0;

  // Timing
  localparam int MCLK_HZ = 20000000;
  localparam int CONV_CLK_BASE_HZ = 256000;
  // Base period rounds down: 20 MHz / 256 kHz = 78 cycles
  localparam int CONV_BASE_DIV = MCLK_HZ / CONV_CLK_BASE_HZ;
  localparam int CONV_PERIODS = 12;
  localparam int RESULT_BITS = 10;
  localparam int CHANNELS = 24;

  // Converter sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;

  // Analogue side: DAC trial code and channel routing
  typedef struct packed {
    logic [RESULT_BITS-1:0] dac_code;
    logic sample;
    logic [CHANNELS-1:0] pin_route;
  } analog_ctrl_t;

endpackage

// [rtl/conv_clock_divider.sv]
`timescale 1ns/1ns
// One-cycle enable at 256, 128, 64 or 32 kHz from mclk
module conv_clock_divider
  import adc_ctrl_pkg::*;
#(
  parameter int BASE_DIV = CONV_BASE_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);

  typedef struct packed {
    logic [6:0] pre;
    logic [2:0] post;
    logic tick;
  } div_state_t;

  div_state_t cur, next_cur;

  // Prescaler to 256 kHz, then power-of-two postscale
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (!run) begin
      // Restart so the first period is always whole
      next_cur.pre = 7'h00;
      next_cur.post = 3'h0;
    end else if (cur.pre == 7'(BASE_DIV - 1)) begin
      next_cur.pre = 7'h00;
      if (cur.post >= 3'((1 << sel) - 1)) begin
        next_cur.post = 3'h0;
        next_cur.tick = 1'b1;
      end else begin
        next_cur.post = cur.post + 3'h1;
      end
    end else begin
      next_cur.pre = cur.pre + 7'h01;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;

  // Ticks at least nine cycles apart, whatever the selected rate
  property p_tick_spaced;
    @(posedge mclk) disable iff (!rst_n)
    tick |=> !tick [*8];
  endproperty
  a_tick_spaced: assert property (p_tick_spaced) else $error("conversion tick too frequent");

endmodule

// [rtl/sar_search.sv]
`timescale 1ns/1ns
// Bitwise successive approximation, MSB first
module sar_search
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH = RESULT_BITS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic step,
  input wire logic comp_above,
  output logic [WIDTH-1:0] trial,
  output logic done
);

  typedef struct packed {
    logic [WIDTH-1:0] code;
    logic [WIDTH-1:0] probe;
    logic done;
  } sar_state_t;

  sar_state_t cur, next_cur;

  // Keep the probed bit when the input is at or above the trial
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (start) begin
      next_cur.probe = {1'b1, {(WIDTH-1){1'b0}}};
      next_cur.code = '0;
    end else if (step && cur.probe != '0) begin
      if (comp_above) begin
        next_cur.code = cur.code | cur.probe;
      end
      next_cur.probe = cur.probe >> 1;
      next_cur.done = (cur.probe[0] == 1'b1);
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Trial word shown to the DAC; all ones reaches full scale
  assign trial = cur.code | cur.probe;
  assign done = cur.done;

endmodule

// [rtl/sar_adc_control.sv]
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
// Contract
// - Ten-bit successive approximation, MSB first
// - Conversion takes twelve conversion-clock periods
// - Channel field picks one of 24 pins
// - Load result, then clear go flag
// - Low register: bits 1,0 at top
// - High register: result bits 9 to 2
// - Two-bit field selects 256 to 32 kHz
// - Reset values 0x1f, zero, zero
// - Only selected pin routed to converter
// - Zero and full-scale code meanings
module sar_adc_control
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic comp_above,
  output analog_ctrl_t analog,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta; // First stage, read only by rst_sync
  logic rst_sync; // Released copy used everywhere

  // Assert at once, release after two edges
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator input sync

  logic comp_meta; // First stage only
  logic comp_sync; // Safe for logic

  // Comparator output is analogue-timed, so two flops
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_above;
      comp_sync <= comp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block state

  typedef struct packed {
    conv_state_t state;
    logic go; // Go flag, also busy
    logic [CHAN_MSB:0] channel; // Channel field
    logic [CLK_SEL_MSB:0] clk_sel; // Conversion clock select
    logic [RESULT_BITS-1:0] result; // Last completed result
    logic [3:0] periods; // Conversion periods counted
    logic irq_done; // Sticky completion event
    logic irq_mask; // Mask for completion event
    logic [7:0] rdata; // Read data, one cycle later
  } ctrl_state_t;

  ctrl_state_t cur, next_cur;

  logic tick; // One conversion clock period elapsed
  logic sar_done; // Last bit decided
  logic [RESULT_BITS-1:0] trial; // Current trial code
  logic sar_start; // Clear the search
  logic sar_step; // Decide one bit

  // Channel code to a one-hot pin route; codes above 23 route nothing
  function automatic logic [CHANNELS-1:0] route_of(input logic [CHAN_MSB:0] ch);
    logic [CHANNELS-1:0] r;
    r = '0;
    if (ch < 5'(CHANNELS)) begin
      r[ch] = 1'b1;
    end
    return r;
  endfunction

  // Register read mux
  function automatic logic [7:0] read_mux(input ctrl_state_t s, input logic [2:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_CHANNEL_SELECT: v = {s.go, 2'b00, s.channel};
      ADDR_RESULT_LOW: v = {s.result[1:0], 6'b000000};
      ADDR_RESULT_HIGH: v = s.result[9:2];
      ADDR_CLOCK_CONTROL: v = {6'b000000, s.clk_sel};
      ADDR_IRQ_STATUS: v = {7'b0000000, s.irq_done};
      ADDR_IRQ_MASK: v = {7'b0000000, s.irq_mask};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_cur = cur;
    sar_start = 1'b0;
    sar_step = 1'b0;
    next_cur.rdata = 8'h00;

    // Read data valid the cycle after the strobe
    if (rd) begin
      next_cur.rdata = read_mux(cur, addr);
      if (addr == ADDR_IRQ_STATUS) begin
        next_cur.irq_done = 1'b0;
      end
    end

    // Register writes
    if (wr) begin
      case (addr)
        ADDR_CHANNEL_SELECT: begin
          // Channel stays fixed while busy so the route holds
          if (!cur.go) begin
            next_cur.channel = wdata[CHAN_MSB:0];
            if (wdata[GO_BIT]) begin
              next_cur.go = 1'b1;
            end
          end
        end
        ADDR_CLOCK_CONTROL: begin
          if (!cur.go) begin
            next_cur.clk_sel = wdata[CLK_SEL_MSB:0];
          end
        end
        ADDR_IRQ_MASK: next_cur.irq_mask = wdata[0];
        default: begin
        end
      endcase
    end

    // Conversion sequencer
    case (cur.state)
      ST_IDLE: begin
        next_cur.periods = 4'h0;
        if (wr && addr == ADDR_CHANNEL_SELECT && !cur.go && wdata[GO_BIT]) begin
          next_cur.state = ST_SAMPLE;
          sar_start = 1'b1;
        end
      end
      ST_SAMPLE: begin
        // Two periods of sample and settle before the ten bit decisions
        if (tick) begin
          next_cur.periods = cur.periods + 4'h1;
          if (cur.periods == 4'(CONV_PERIODS - RESULT_BITS - 1)) begin
            next_cur.state = ST_CONVERT;
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          next_cur.periods = cur.periods + 4'h1;
          sar_step = 1'b1;
        end
        if (sar_done) begin
          // Result and go clear land together, result visible first read
          next_cur.result = trial;
          next_cur.go = 1'b0;
          next_cur.irq_done = 1'b1; // Set wins over read clear
          next_cur.state = ST_IDLE;
        end
      end
      default: next_cur.state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      cur <= '0;
      cur.state <= ST_IDLE;
      cur.channel <= CHANNEL_SELECT_RESET[CHAN_MSB:0];
      cur.clk_sel <= CLOCK_CONTROL_RESET;
      cur.result <= {RESULT_RESET, RESULT_RESET[1:0]};
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Children

  conv_clock_divider u_div (
    .mclk(mclk),
    .rst_n(rst_sync),
    .run(cur.state != ST_IDLE),
    .sel(cur.clk_sel),
    .tick(tick)
  );

  sar_search u_sar (
    .mclk(mclk),
    .rst_n(rst_sync),
    .start(sar_start),
    .step(sar_step),
    .comp_above(comp_sync),
    .trial(trial),
    .done(sar_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata = cur.rdata;
  assign irq = cur.irq_done & cur.irq_mask;
  assign analog.dac_code = trial;
  assign analog.sample = (cur.state == ST_SAMPLE);
  // Pin goes analogue only while converting; others keep port function
  assign analog.pin_route = (cur.state != ST_IDLE) ? route_of(cur.channel) : '0;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_go_write;
    wr && addr == ADDR_CHANNEL_SELECT && wdata[GO_BIT] && !cur.go;
  endsequence

  property p_go_starts;
    @(posedge mclk) disable iff (!rst_sync)
    s_go_write |=> cur.go && cur.state == ST_SAMPLE;
  endproperty
  a_go_starts: assert property (p_go_starts) else $error("go write did not start");

  property p_done_clears_go;
    @(posedge mclk) disable iff (!rst_sync)
    sar_done |=> !cur.go && cur.result == $past(trial) && cur.irq_done;
  endproperty
  a_done_clears_go: assert property (p_done_clears_go) else $error("completion order wrong");

  property p_busy_keeps_result;
    @(posedge mclk) disable iff (!rst_sync)
    cur.go && !sar_done |=> $stable(cur.result) && $stable(cur.channel);
  endproperty
  a_busy_keeps_result: assert property (p_busy_keeps_result) else $error("result changed while busy");

  property p_twelve_periods;
    @(posedge mclk) disable iff (!rst_sync)
    sar_done |-> cur.periods == 4'(CONV_PERIODS);
  endproperty
  a_twelve_periods: assert property (p_twelve_periods) else $error("conversion not twelve periods");

  property p_low_layout;
    @(posedge mclk) disable iff (!rst_sync)
    rd && addr == ADDR_RESULT_LOW |=> rdata == {$past(cur.result[1:0]), 6'b000000};
  endproperty
  a_low_layout: assert property (p_low_layout) else $error("low result layout wrong");

  property p_high_layout;
    @(posedge mclk) disable iff (!rst_sync)
    rd && addr == ADDR_RESULT_HIGH |=> rdata == $past(cur.result[9:2]);
  endproperty
  a_high_layout: assert property (p_high_layout) else $error("high result layout wrong");

  property p_route_onehot;
    @(posedge mclk) disable iff (!rst_sync)
    cur.state != ST_IDLE && cur.channel < 5'(CHANNELS) |-> $onehot(analog.pin_route);
  endproperty
  a_route_onehot: assert property (p_route_onehot) else $error("pin route not single");

  property p_idle_no_route;
    @(posedge mclk) disable iff (!rst_sync)
    cur.state == ST_IDLE |-> analog.pin_route == '0 && !cur.go;
  endproperty
  a_idle_no_route: assert property (p_idle_no_route) else $error("route while idle");

  property p_reset_values;
    @(posedge mclk) $rose(rst_sync) |-> cur.channel == 5'h1f && !cur.go && cur.result == '0;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  // Status read clears the event unless a completion lands in the same cycle
  property p_status_read_clears;
    @(posedge mclk) disable iff (!rst_sync)
    rd && addr == ADDR_IRQ_STATUS && !sar_done |=> !cur.irq_done;
  endproperty
  a_status_read_clears: assert property (p_status_read_clears) else $error("status read did not clear");

  // Rate stays fixed while busy, or the period count would be meaningless
  property p_busy_keeps_clock;
    @(posedge mclk) disable iff (!rst_sync)
    cur.go && wr && addr == ADDR_CLOCK_CONTROL |=> $stable(cur.clk_sel);
  endproperty
  a_busy_keeps_clock: assert property (p_busy_keeps_clock) else $error("clock select changed while busy");

endmodule

// [test/adc_far_side.sv]
`timescale 1ns/1ns
// Comparator and input mux standing behind the converter pins
module adc_far_side
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire analog_ctrl_t analog,
  input wire logic [RESULT_BITS-1:0] level [CHANNELS],
  output logic comp_above
);
  int hit; // Number of pins routed at once
  logic [RESULT_BITS-1:0] vin; // Level of the routed pin

  initial begin
    comp_above = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Compare the one routed pin with the trial code, one cycle late
  always @(posedge mclk) begin
    hit = 0;
    vin = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      // Only a routed pin reaches the comparator
      if (analog.pin_route[i]) begin
        hit++;
        vin = level[i];
      end
    end
    // Input at or above trial reads high, so the search lands on the level
    if (hit == 1) begin
      comp_above <= (vin >= analog.dac_code);
    end else begin
      // No pin or a short: output toggles so a stale answer shows up
      comp_above <= ~comp_above;
    end
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ns
// Register-level test of the converter control
module testbench;
  import adc_ctrl_pkg::*;

  logic mclk; // 20 MHz clock
  logic resetn; // Active low reset
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic comp_above;
  analog_ctrl_t analog;
  logic irq;
  logic [RESULT_BITS-1:0] level [CHANNELS]; // Pin voltages in LSB units
  int errors;
  int cmp_count;
  int cyc; // Free-running cycle count
  logic [7:0] prev_hi; // Last result high byte

  sar_adc_control i_sar_adc_control (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .comp_above(comp_above), .analog(analog), .irq(irq)
  );

  adc_far_side i_adc_far_side (.mclk(mclk), .analog(analog), .level(level), .comp_above(comp_above));

  ////////////////////////////////////////////////////////////////
  // Clock and cycle count
  initial begin
    mclk = 1'b0;
  end
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Single ending for pass, fail and hang
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // One conversion with busy probes, timing, result and interrupt
  task automatic convert(input logic [4:0] ch, input logic [1:0] sel, input logic [9:0] v, input logic m);
    int t0;
    int per;
    int n;
    logic [7:0] d;
    per = CONV_BASE_DIV << sel;
    level[ch] = v;
    wr_reg(ADDR_IRQ_MASK, {7'h0, m});
    wr_reg(ADDR_CLOCK_CONTROL, {6'h0, sel});
    t0 = cyc;
    wr_reg(ADDR_CHANNEL_SELECT, {3'b100, ch});
    repeat (2) @(posedge mclk);
    #1 check32(32'(analog.pin_route), 32'h1 << ch);
    check32(32'(analog.sample), 32'h1);
    // Busy: these writes must be dropped; the clock value differs in every mode
    wr_reg(ADDR_CHANNEL_SELECT, {3'b100, ch ^ 5'h01});
    wr_reg(ADDR_CLOCK_CONTROL, {6'h0, ~sel});
    rd_reg(ADDR_CHANNEL_SELECT, d);
    check8(d, {3'b100, ch});
    rd_reg(ADDR_RESULT_HIGH, d);
    check8(d, prev_hi);
    // Poll the go flag, bounded
    n = 0;
    do begin
      rd_reg(ADDR_CHANNEL_SELECT, d);
      n++;
    end while (d[GO_BIT] !== 1'b0 && n < 20000);
    check8(d, {3'b000, ch});
    // Search ends on the pin level; sampling phase is over
    check32(32'(analog.dac_code), 32'(v));
    check32(32'(analog.sample), 32'h0);
    // Twelve conversion periods, one period of divider phase slack
    check32(32'((cyc - t0) >= 12 * per - 4 && (cyc - t0) <= 13 * per + 20), 32'h1);
    rd_reg(ADDR_RESULT_LOW, d);
    check8(d, {v[1:0], 6'h00});
    rd_reg(ADDR_RESULT_HIGH, d);
    check8(d, v[9:2]);
    prev_hi = v[9:2];
    rd_reg(ADDR_CLOCK_CONTROL, d);
    check8(d, {6'h0, sel});
    check32(32'(irq), 32'(m));
    rd_reg(ADDR_IRQ_STATUS, d);
    check8(d, 8'h01);
    @(posedge mclk);
    #1 check32(32'(irq), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] d;
    resetn = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    prev_hi = RESULT_RESET;
    // Distinct levels so a wrong pin gives a wrong code
    for (int i = 0; i < CHANNELS; i++) begin
      level[i] = 10'h155 ^ 10'(i * 37);
    end
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    // Writes to read-only and unmapped places change nothing
    wr_reg(3'h7, 8'hff);
    wr_reg(ADDR_RESULT_LOW, 8'hff);
    wr_reg(ADDR_RESULT_HIGH, 8'hff);
    rd_reg(ADDR_CHANNEL_SELECT, d);
    check8(d, CHANNEL_SELECT_RESET);
    rd_reg(ADDR_RESULT_LOW, d);
    check8(d, RESULT_RESET);
    rd_reg(ADDR_RESULT_HIGH, d);
    check8(d, RESULT_RESET);
    rd_reg(ADDR_CLOCK_CONTROL, d);
    check8(d, {6'h0, CLOCK_CONTROL_RESET});
    rd_reg(3'h7, d);
    check8(d, 8'h00);
    // Read data stand one cycle only, then fall back to zero
    @(posedge mclk);
    #1 check8(rdata, 8'h00);
    // Idle: no pin routed
    check32(32'(analog.pin_route), 32'h0);
    // Unused control bits read as zero
    wr_reg(ADDR_CLOCK_CONTROL, 8'hff);
    rd_reg(ADDR_CLOCK_CONTROL, d);
    check8(d, 8'h03);
    // Port boundaries, code extremes, every clock rate
    convert(5'd0, 2'd0, 10'h000, 1'b1);
    convert(5'd7, 2'd0, 10'h3ff, 1'b0);
    convert(5'd8, 2'd0, 10'h201, 1'b1);
    convert(5'd15, 2'd1, 10'h1fe, 1'b0);
    convert(5'd16, 2'd2, 10'h2aa, 1'b1);
    convert(5'd23, 2'd3, 10'h155, 1'b1);
    convert(5'd12, 2'd0, 10'h0c3, 1'b0);
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////
  // Watchdog: the run needs about 17000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    wrap_up;
  end
endmodule
